// ---- linreg_bank.sv ----
// linear regulator control bank: apb register file and per-regulator decode
// assumes an external sequencer supplies power state, slot strobes and fault pulses
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module linreg_bank (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       sm_reset,
    input  wire linreg_pkg::power_state_type power_state,
    input  wire logic                       slot_strobe,
    input  wire logic [3:0]                 seq_slot,
    input  wire logic                       low_power_input_a,
    input  wire logic                       low_power_input_b,
    input  wire logic                       low_power_input_c,
    input  wire logic                       gpio_sleep_in,
    input  wire logic [2:0]                 reg_fault,
    input  wire logic                       reg4_on_in,
    input  wire logic                       switch_on_in,
    output logic      [2:0]                 reg_on,
    output logic      [2:0]                 reg_switch_select,
    output logic      [2:0][11:0]           reg_millivolts,
    output logic      [3:0]                 reg_discharge,
    output logic                            reg4_switch_select,
    output logic      [11:0]                reg4_millivolts,
    output logic                            switch_sleep_disable,
    output logic                            switch_bulk_detect,
    output logic                            system_shutdown_req,
    output logic                            irq
);
    import linreg_pkg::*;

    function automatic logic [11:0] code_to_mv(input logic [4:0] code);
        if (code < CODE_SPLIT) begin
            return MV_LOW_BASE + 12'(code) * MV_LOW_STEP;
        end
        return MV_HIGH_BASE + 12'(code - CODE_SPLIT) * MV_HIGH_STEP;
    endfunction

    function automatic logic in_bank(input logic [7:0] idx);
        return (idx >= IDX_LIMIT_SWITCH) && (idx <= IDX_REGULATOR4_CONTROL);
    endfunction

    logic [15:0]     regs_reg [REG_COUNT];
    logic [2:0]      irq_status_reg;
    logic [2:0]      irq_mask_reg;
    logic            sleep_sw_reg;
    logic [2:0]      enable_reg;
    logic            was_active_reg;
    logic            was_off_reg;
    logic            prev_sleep_reg;
    logic [7:0]      idx;
    logic [7:0]      slot;
    logic            addr_ok;
    logic            wr_fire;
    logic [2:0]      on_next;
    logic [2:0][4:0] vcode_next;
    logic [2:0]      sleep_now;
    logic            all_off;
    logic            sw_sleep;
    logic            entering_active;
    logic            entering_off;

    assign idx     = paddr[9:2];
    assign slot    = idx - IDX_LIMIT_SWITCH;
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                     (in_bank(idx) || idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK ||
                      idx == IDX_SLEEP_SOFTWARE);
    assign wr_fire = psel && penable && pwrite && addr_ok;
    // zero wait states; read data is captured in the setup cycle
    assign pready  = 1'b1;

    assign entering_active = (power_state == PS_ACTIVE) && !was_active_reg;
    assign entering_off    = (power_state == PS_OFF) && !was_off_reg;
    assign sw_sleep        = sleep_sw_reg || gpio_sleep_in;

    // ---------------- register file ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < REG_COUNT; k++) begin
                regs_reg[k] <= REG_DEFAULTS[k];
            end
        end else if (sm_reset) begin
            for (int k = 0; k < REG_COUNT; k++) begin
                regs_reg[k] <= REG_DEFAULTS[k];
            end
        end else if (wr_fire && in_bank(idx)) begin
            regs_reg[slot[3:0]] <= pwdata[15:0] & REG_WRITABLE[slot[3:0]];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_sw_reg <= 1'b0;
        end else if (sm_reset) begin
            sleep_sw_reg <= 1'b0;
        end else if (wr_fire && idx == IDX_SLEEP_SOFTWARE) begin
            sleep_sw_reg <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= IRQ_MASK_DEFAULT;
        end else if (wr_fire && idx == IDX_IRQ_MASK) begin
            irq_mask_reg <= pwdata[2:0];
        end
    end

    // write-one-to-clear; a fault in the same cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= 3'h0;
        end else begin
            irq_status_reg <= (irq_status_reg &
                               ~((wr_fire && idx == IDX_IRQ_STATUS) ? pwdata[2:0] : 3'h0))
                              | reg_fault;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= !addr_ok;
            if (!addr_ok) begin
                prdata <= 32'h0000_0000;
            end else if (in_bank(idx)) begin
                prdata <= {16'h0000, regs_reg[slot[3:0]]};
            end else if (idx == IDX_IRQ_STATUS) begin
                prdata <= {29'h0, irq_status_reg};
            end else if (idx == IDX_IRQ_MASK) begin
                prdata <= {29'h0, irq_mask_reg};
            end else begin
                prdata <= {31'h0, sleep_sw_reg};
            end
        end
    end

    // ---------------- sequencing ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            was_active_reg <= 1'b0;
            was_off_reg    <= 1'b1;
        end else begin
            was_active_reg <= (power_state == PS_ACTIVE);
            was_off_reg    <= (power_state == PS_OFF);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg <= 3'h0;
        end else if (sm_reset) begin
            enable_reg <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                logic [15:0] seqw;
                logic [3:0]  start_s;
                logic [3:0]  stop_s;
                seqw    = regs_reg[2 + 3 * i];
                start_s = seqw[START_SLOT_LSB +: 4];
                stop_s  = seqw[STOP_SLOT_LSB +: 4];
                if (reg_fault[i] && seqw[FAULT_ACTION_LSB +: 2] == ACTION_REG_OFF) begin
                    enable_reg[i] <= 1'b0;
                end else if (power_state == PS_STARTUP && slot_strobe &&
                             seq_slot == start_s && start_s != SLOT_NONE &&
                             start_s != SLOT_ALL) begin
                    enable_reg[i] <= 1'b1;
                end else if (entering_active && start_s == SLOT_ALL) begin
                    enable_reg[i] <= 1'b1;
                end else if (power_state == PS_SHUTDOWN && slot_strobe &&
                             seq_slot == stop_s && stop_s != SLOT_NONE &&
                             stop_s != SLOT_ALL) begin
                    enable_reg[i] <= 1'b0;
                end else if (entering_off && (stop_s == SLOT_NONE || stop_s == SLOT_ALL)) begin
                    enable_reg[i] <= 1'b0;
                end
            end
        end
    end

    // codes 10 and 11 demand a system shutdown
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_shutdown_req <= 1'b0;
        end else begin
            system_shutdown_req <= |(reg_fault & {regs_reg[8][FAULT_ACTION_LSB + 1],
                                                  regs_reg[5][FAULT_ACTION_LSB + 1],
                                                  regs_reg[2][FAULT_ACTION_LSB + 1]});
        end
    end

    // ---------------- hibernate and output decode ----------------
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            logic [15:0] lpw;
            logic [15:0] ctw;
            lpw = regs_reg[3 + 3 * i];
            ctw = regs_reg[1 + 3 * i];
            case (lpw[SOURCE_LSB +: 2])
                SRC_SOFTWARE: sleep_now[i] = sleep_sw_reg;
                SRC_INPUT_A:  sleep_now[i] = low_power_input_a;
                SRC_INPUT_B:  sleep_now[i] = low_power_input_b;
                default:      sleep_now[i] = low_power_input_c;
            endcase
            sleep_now[i] = sleep_now[i] || gpio_sleep_in;
            // reserved behaviour codes leave the active settings untouched
            on_next[i] = enable_reg[i] &&
                         !(sleep_now[i] && lpw[BEHAVIOUR_LSB +: 2] == BEHAV_OFF);
            if (sleep_now[i] && lpw[BEHAVIOUR_LSB +: 2] == BEHAV_IMAGE) begin
                vcode_next[i] = lpw[VCODE_LSB +: 5];
            end else begin
                vcode_next[i] = ctw[VCODE_LSB +: 5];
            end
        end
        all_off = !(|on_next) && !reg4_on_in;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_on            <= 3'h0;
            reg_switch_select <= 3'h0;
            reg_millivolts    <= '0;
            reg_discharge     <= 4'hF;
        end else begin
            for (int i = 0; i < 3; i++) begin
                reg_on[i]            <= on_next[i];
                reg_switch_select[i] <= regs_reg[1 + 3 * i][MODE_BIT];
                reg_millivolts[i]    <= regs_reg[1 + 3 * i][MODE_BIT] ? 12'h000
                                        : code_to_mv(vcode_next[i]);
                reg_discharge[i]     <= !on_next[i] &&
                                        (!regs_reg[1 + 3 * i][FLOAT_BIT] || all_off);
            end
            reg_discharge[3] <= !reg4_on_in && (!regs_reg[10][FLOAT_BIT] || all_off);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg4_switch_select <= 1'b0;
            reg4_millivolts    <= 12'h000;
        end else begin
            reg4_switch_select <= regs_reg[10][MODE_BIT];
            reg4_millivolts    <= regs_reg[10][MODE_BIT] ? 12'h000
                                  : code_to_mv(regs_reg[10][VCODE_LSB +: 5]);
        end
    end

    // ---------------- current limit switch ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_sleep_disable <= 1'b0;
            switch_bulk_detect   <= 1'b1;
            prev_sleep_reg       <= 1'b0;
        end else begin
            logic sw_off;
            sw_off = !switch_on_in || (sw_sleep && !regs_reg[0][SWITCH_KEEP_BIT]);
            prev_sleep_reg       <= sw_sleep;
            switch_sleep_disable <= sw_sleep && !regs_reg[0][SWITCH_KEEP_BIT];
            switch_bulk_detect   <= sw_off && (sw_sleep ? regs_reg[0][SLEEP_BULK_BIT]
                                                        : regs_reg[0][ACTIVE_BULK_BIT]);
        end
    end

    // ---------------- checks ----------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence fault_hit_reg_off;
        reg_fault[0] && regs_reg[2][FAULT_ACTION_LSB +: 2] == ACTION_REG_OFF;
    endsequence
    sequence start_slot_hit;
        power_state == PS_STARTUP && slot_strobe && !sm_reset && !reg_fault[0] &&
        seq_slot == regs_reg[2][START_SLOT_LSB +: 4] &&
        regs_reg[2][START_SLOT_LSB +: 4] != SLOT_NONE &&
        regs_reg[2][START_SLOT_LSB +: 4] != SLOT_ALL;
    endsequence

    AST_SWITCH_SLEEP: assert property (sw_sleep && !regs_reg[0][SWITCH_KEEP_BIT]
        |=> switch_sleep_disable) else $error("switch not disabled in hibernate");
    AST_SLEEP_BULK: assert property (!switch_on_in && sw_sleep &&
        !regs_reg[0][SLEEP_BULK_BIT] |=> !switch_bulk_detect)
        else $error("bulk detect active against hibernate setting");
    AST_ACTIVE_BULK: assert property (!switch_on_in && !sw_sleep &&
        regs_reg[0][ACTIVE_BULK_BIT] |=> switch_bulk_detect)
        else $error("bulk detect missing while switch off");
    AST_SWITCH_MODE: assert property (regs_reg[1][MODE_BIT]
        |=> reg_millivolts[0] == 12'h000 && reg_switch_select[0])
        else $error("voltage code used in switch mode");
    AST_FLOAT_OUT: assert property (reg_discharge[0] |-> !reg_on[0])
        else $error("discharge while regulator on");
    AST_ALL_OFF: assert property ((reg_on == 3'h0) && !$past(reg4_on_in)
        |-> reg_discharge == 4'hF) else $error("outputs not all discharged");
    AST_VOLT_MAP: assert property (!regs_reg[1][MODE_BIT] && !sleep_now[0] &&
        regs_reg[1][4:0] == 5'h0F |=> reg_millivolts[0] == 12'h672)
        else $error("code 01111 is not 1.65 V");
    AST_FAULT_IRQ: assert property (reg_fault[1]
        |=> irq_status_reg[1] ##0 (irq == irq_mask_reg[1]) or irq)
        else $error("fault did not raise interrupt status");
    AST_FAULT_OFF: assert property (fault_hit_reg_off |=> !enable_reg[0] ##1 !reg_on[0])
        else $error("regulator not shut down on fault");
    AST_START_SLOT: assert property (start_slot_hit |=> enable_reg[0])
        else $error("regulator missed its start slot");
    AST_STOP_OFF: assert property (entering_off && !sm_reset &&
        regs_reg[2][STOP_SLOT_LSB +: 4] == SLOT_NONE && !start_slot_hit |=> !enable_reg[0])
        else $error("regulator kept on entering off");
    AST_SLEEP_OFF: assert property (gpio_sleep_in &&
        regs_reg[3][BEHAVIOUR_LSB +: 2] == BEHAV_OFF |=> !reg_on[0])
        else $error("hibernate did not disable output");
    AST_SLEEP_SRC: assert property (regs_reg[6][SOURCE_LSB +: 2] == SRC_INPUT_B &&
        low_power_input_b |-> sleep_now[1]) else $error("hibernate source ignored");
    AST_IMAGE: assert property (sleep_now[0] && !regs_reg[1][MODE_BIT] &&
        regs_reg[3][BEHAVIOUR_LSB +: 2] == BEHAV_IMAGE && regs_reg[3][4:0] == 5'h1C
        |=> reg_millivolts[0] == 12'hBB8) else $error("image voltage not applied");
    AST_SM_RESET: assert property (sm_reset |=> regs_reg[3] == 16'h001C &&
        regs_reg[0] == 16'h0003 ##1 !$stable(sm_reset) or regs_reg[3] == 16'h001C)
        else $error("state machine reset left fields changed");

endmodule // linreg_bank
`default_nettype wire

// ---- linreg_pkg.sv ----
// constants, register map and types for the linear regulator control bank
// assumes word-aligned apb access; register index times four is the byte address
package linreg_pkg;

    localparam int REG_COUNT = 11;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_LIMIT_SWITCH       = 8'hC7;
    localparam logic [7:0] IDX_REGULATOR1_CONTROL = 8'hC8;
    localparam logic [7:0] IDX_REGULATOR1_SEQ     = 8'hC9;
    localparam logic [7:0] IDX_REGULATOR1_LOWPWR  = 8'hCA;
    localparam logic [7:0] IDX_REGULATOR2_CONTROL = 8'hCB;
    localparam logic [7:0] IDX_REGULATOR2_SEQ     = 8'hCC;
    localparam logic [7:0] IDX_REGULATOR2_LOWPWR  = 8'hCD;
    localparam logic [7:0] IDX_REGULATOR3_CONTROL = 8'hCE;
    localparam logic [7:0] IDX_REGULATOR3_SEQ     = 8'hCF;
    localparam logic [7:0] IDX_REGULATOR3_LOWPWR  = 8'hD0;
    localparam logic [7:0] IDX_REGULATOR4_CONTROL = 8'hD1;
    localparam logic [7:0] IDX_IRQ_STATUS         = 8'hE8;
    localparam logic [7:0] IDX_IRQ_MASK           = 8'hE9;
    localparam logic [7:0] IDX_SLEEP_SOFTWARE     = 8'hEA;

    // field positions
    localparam int SWITCH_KEEP_BIT   = 4;
    localparam int SLEEP_BULK_BIT    = 1;
    localparam int ACTIVE_BULK_BIT   = 0;
    localparam int MODE_BIT          = 14;
    localparam int FLOAT_BIT         = 10;
    localparam int VCODE_LSB         = 0;
    localparam int FAULT_ACTION_LSB  = 14;
    localparam int START_SLOT_LSB    = 10;
    localparam int STOP_SLOT_LSB     = 6;
    localparam int BEHAVIOUR_LSB     = 12;
    localparam int SOURCE_LSB        = 8;

    // field codes
    localparam logic [3:0] SLOT_NONE      = 4'h0;
    localparam logic [3:0] SLOT_ALL       = 4'hF;
    localparam logic [1:0] ACTION_REG_OFF = 2'h1;
    localparam logic [1:0] BEHAV_IMAGE    = 2'h0;
    localparam logic [1:0] BEHAV_OFF      = 2'h1;
    localparam logic [1:0] SRC_SOFTWARE   = 2'h0;
    localparam logic [1:0] SRC_INPUT_A    = 2'h1;
    localparam logic [1:0] SRC_INPUT_B    = 2'h2;

    // voltage code mapping in millivolts
    localparam logic [4:0]  CODE_SPLIT   = 5'h10;
    localparam logic [11:0] MV_LOW_BASE  = 12'h384;
    localparam logic [11:0] MV_LOW_STEP  = 12'h032;
    localparam logic [11:0] MV_HIGH_BASE = 12'h708;
    localparam logic [11:0] MV_HIGH_STEP = 12'h064;

    // defaults of this variant, and the bits software may write
    localparam logic [15:0] REG_DEFAULTS [REG_COUNT] = '{
        16'h0003, 16'h001C, 16'h0000, 16'h001C, 16'h001B, 16'h0000,
        16'h001C, 16'h001B, 16'h0000, 16'h001C, 16'h001B};
    localparam logic [15:0] REG_WRITABLE [REG_COUNT] = '{
        16'h0013, 16'h441F, 16'hFFC0, 16'h331F, 16'h441F, 16'hFFC0,
        16'h331F, 16'h441F, 16'hFFC0, 16'h331F, 16'h441F};

    localparam logic [2:0] IRQ_MASK_DEFAULT = 3'h0;

    typedef enum logic [1:0] {PS_OFF, PS_STARTUP, PS_ACTIVE, PS_SHUTDOWN} power_state_type;

endpackage

// ---- tb_top.sv ----
// testbench for the linear regulator control bank: apb tasks and directed tests
// assumes zero-wait apb slave and a sequencer whose inputs are driven from here
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
    import linreg_pkg::*;
    logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, rd;
    logic                  sm_reset, slot_strobe, gpio_sleep_in, reg4_on_in, switch_on_in;
    logic [2:0]            lp_in, reg_fault, reg_on, reg_switch_select;
    logic [3:0]            seq_slot, reg_discharge;
    power_state_type       power_state;
    logic [2:0][11:0]      reg_millivolts;
    logic [11:0]           reg4_millivolts;
    logic                  reg4_switch_select, switch_sleep_disable, switch_bulk_detect;
    logic                  system_shutdown_req, irq, err;
    int                    err_total = 0, num_checks = 0;
    logic [4:0]            codes [4] = '{5'h00, 5'h0F, 5'h10, 5'h1F};

    linreg_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sm_reset(sm_reset), .power_state(power_state),
        .slot_strobe(slot_strobe), .seq_slot(seq_slot), .low_power_input_a(lp_in[0]),
        .low_power_input_b(lp_in[1]), .low_power_input_c(lp_in[2]),
        .gpio_sleep_in(gpio_sleep_in), .reg_fault(reg_fault), .reg4_on_in(reg4_on_in),
        .switch_on_in(switch_on_in), .reg_on(reg_on), .reg_switch_select(reg_switch_select),
        .reg_millivolts(reg_millivolts), .reg_discharge(reg_discharge),
        .reg4_switch_select(reg4_switch_select), .reg4_millivolts(reg4_millivolts),
        .switch_sleep_disable(switch_sleep_disable), .switch_bulk_detect(switch_bulk_detect),
        .system_shutdown_req(system_shutdown_req), .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    function automatic logic [11:0] mv(input logic [4:0] c);
        int v;
        v = (c < 5'h10) ? 900 + 50 * int'(c) : 1800 + 100 * (int'(c) - 16);
        return 12'(v);
    endfunction

    // request held from setup until the edge where pready is sampled high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {2'h0, idx, 2'h0}; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        apb(1'b1, idx, {16'h0000, d});
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [15:0] e);
        apb(1'b0, idx, 32'h0000_0000);
        `CHK(rd, {16'h0000, e})
    endtask
    task automatic settle();
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask
    // slots only count in the start-up or shutdown state; active again afterwards
    task automatic strobe(input power_state_type ps, input logic [3:0] s);
        @(posedge pclk);
        power_state <= ps; slot_strobe <= 1'b1; seq_slot <= s;
        @(posedge pclk);
        slot_strobe <= 1'b0; power_state <= PS_ACTIVE;
        settle();
    endtask
    task automatic fault_pulse();
        @(posedge pclk);
        reg_fault <= 3'h3;
        @(posedge pclk);
        reg_fault <= 3'h0;
        @(negedge pclk);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        close_out();
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; sm_reset = 1'b0; power_state = PS_ACTIVE; slot_strobe = 1'b0;
        seq_slot = 4'h0; lp_in = 3'h0; gpio_sleep_in = 1'b0; reg_fault = 3'h0;
        reg4_on_in = 1'b1; switch_on_in = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < REG_COUNT; i++) rd_chk(8'hC7 + 8'(i), REG_DEFAULTS[i]);
        rd_chk(8'hCA, 16'h001C);
        for (int i = 0; i < REG_COUNT; i++) wr(8'hC7 + 8'(i), 16'hFFFF);
        for (int i = 0; i < REG_COUNT; i++) rd_chk(8'hC7 + 8'(i), REG_WRITABLE[i]);
        @(posedge pclk) sm_reset <= 1'b1;
        @(posedge pclk) sm_reset <= 1'b0;
        for (int i = 0; i < REG_COUNT; i++) rd_chk(8'hC7 + 8'(i), REG_DEFAULTS[i]);
        apb(1'b0, 8'h80, 32'h0);
        `CHK(err, 1'b1)
        `CHK(reg4_millivolts, mv(5'h1B))
        `CHK(reg4_switch_select, 1'b0)
        done("registers");
        // start in slot 1, then walk the voltage code boundaries
        wr(8'hC9, 16'h0400);
        strobe(PS_STARTUP, 4'h1);
        `CHK(reg_on[0], 1'b1)
        for (int i = 0; i < 4; i++) begin
            wr(8'hC8, {11'h000, codes[i]});
            settle();
            `CHK(reg_millivolts[0], mv(codes[i]))
        end
        wr(8'hC8, 16'h401F);
        settle();
        `CHK(reg_switch_select[0], 1'b1)
        `CHK(reg_millivolts[0], 12'h000)
        done("voltage");
        wr(8'hC8, 16'h0400);
        wr(8'hC9, 16'h0480);
        strobe(PS_SHUTDOWN, 4'h2);
        `CHK(reg_on[0], 1'b0)
        `CHK(reg_discharge[0], 1'b0)
        reg4_on_in <= 1'b0;
        settle();
        `CHK(reg_discharge[0], 1'b1)
        reg4_on_in <= 1'b1;
        wr(8'hC8, 16'h0010);
        settle();
        `CHK(reg_discharge[0], 1'b1)
        done("discharge");
        wr(8'hC9, 16'h8400);
        wr(8'hE9, 16'h0001);
        strobe(PS_STARTUP, 4'h1);
        fault_pulse();
        `CHK(system_shutdown_req, 1'b1)
        `CHK(irq, 1'b1)
        rd_chk(8'hE8, 16'h0003);
        wr(8'hE8, 16'h0001);
        settle();
        `CHK(irq, 1'b0)
        wr(8'hC9, 16'h4400);
        fault_pulse();
        settle();
        `CHK(reg_on[0], 1'b0)
        `CHK(irq, 1'b1)
        wr(8'hE9, 16'h0000);
        settle();
        `CHK(irq, 1'b0)
        wr(8'hE8, 16'h0001);
        done("fault");
        wr(8'hC9, 16'h0400);
        strobe(PS_STARTUP, 4'h1);
        for (int s = 0; s < 4; s++) begin
            wr(8'hCA, 16'(s << 8) | 16'h001C);
            if (s == 0) wr(8'hEA, 16'h0001);
            else lp_in <= 3'(1 << (s - 1));
            settle();
            `CHK(reg_millivolts[0], mv(5'h1C))
            if (s == 0) wr(8'hEA, 16'h0000);
            lp_in <= 3'h0;
            settle();
            `CHK(reg_millivolts[0], mv(5'h10))
        end
        gpio_sleep_in <= 1'b1;
        settle();
        `CHK(reg_millivolts[0], mv(5'h1C))
        wr(8'hCA, 16'h111C);
        settle();
        `CHK(reg_on[0], 1'b0)
        gpio_sleep_in <= 1'b0;
        done("hibernate");
        wr(8'hC9, 16'h3C00);
        power_state <= PS_OFF;
        settle();
        `CHK(reg_on[0], 1'b0)
        power_state <= PS_ACTIVE;
        settle();
        `CHK(reg_on[0], 1'b1)
        done("state");
        wr(8'hC7, 16'h0000);
        wr(8'hEA, 16'h0001);
        switch_on_in <= 1'b1;
        settle();
        `CHK(switch_sleep_disable, 1'b1)
        `CHK(switch_bulk_detect, 1'b0)
        wr(8'hC7, 16'h0002);
        settle();
        `CHK(switch_bulk_detect, 1'b1)
        wr(8'hC7, 16'h0010);
        settle();
        `CHK(switch_sleep_disable, 1'b0)
        wr(8'hEA, 16'h0000);
        switch_on_in <= 1'b0;
        wr(8'hC7, 16'h0001);
        settle();
        `CHK(switch_bulk_detect, 1'b1)
        wr(8'hC7, 16'h0000);
        settle();
        `CHK(switch_bulk_detect, 1'b0)
        done("switch");
        close_out();
    end
endmodule // tb_top
`default_nettype wire
